// [bccbe_mem_model.sv]
/* bccbe_mem_model: byte memory on the processor bus of bccbe_top.
   assumes the block holds a request until ack; answers after dly_i cycles. */
`timescale 1ns/1ps

module bccbe_mem_model (
  input  wire logic        clk_i,
  input  wire logic        cyc_i,
  input  wire logic        we_i,
  input  wire logic        word_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [7:0]  dat_i,
  input  wire logic [3:0]  dly_i,
  output logic      [15:0] dat_o,
  output logic             ack_o
);
  logic [7:0] m [256];
  logic [7:0] a;
  logic [3:0] cnt_r = 4'h0;

  assign a = adr_i[7:0];
  initial ack_o = 1'b0;
  initial dat_o = 16'h0000;

  // one ack pulse a request; idle data flips so stale values never match
  always @(posedge clk_i) begin
    if (ack_o || !cyc_i) begin
      ack_o <= 1'b0;
      cnt_r <= 4'h0;
      dat_o <= ~dat_o;
    end else if (cnt_r == dly_i) begin
      ack_o <= 1'b1;
      if (we_i) m[a] <= dat_i;
      dat_o <= word_i ? {m[a], m[a + 8'h01]} : {~m[a], m[a]};
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule // bccbe_mem_model

// [bccbe_pkg.sv]
/*
 * bccbe_pkg: constants and types for the bit test-invert / test-clear /
 * branch-always execution block (register map, opcode fields, ccr layout).
 * Assumes a single synchronous clock domain and one importing top module.
 */
package bccbe_pkg;

  // register byte offsets on the wishbone slave
  localparam logic [7:0] ADR_OPCODE    = 8'h00;  // write starts execution
  localparam logic [7:0] ADR_PC        = 8'h04;
  localparam logic [7:0] ADR_CCR       = 8'h08;
  localparam logic [7:0] ADR_EA        = 8'h0C;  // resolved operand byte address
  localparam logic [7:0] ADR_STATUS    = 8'h10;
  localparam logic [7:0] ADR_DREG_BASE = 8'h20;  // eight data registers, 4 bytes apart
  localparam logic [7:0] ADR_DREG_MASK = 8'hE0;

  // status register bit positions
  localparam int unsigned ST_BUSY    = 0;
  localparam int unsigned ST_DONE    = 1;
  localparam int unsigned ST_INVALID = 2;
  localparam int unsigned ST_ILLEGAL = 3;

  // condition code layout: x n z v c
  localparam int unsigned CCR_W = 5;
  localparam int unsigned CCR_Z = 2;

  // opcode encodings
  localparam logic [7:0] OPC_BRANCH_HI = 8'h60;
  localparam logic [7:0] OPC_STATIC_HI = 8'h08;
  localparam logic [3:0] OPC_DYN_TOP   = 4'h0;
  localparam logic [1:0] OP_INVERT     = 2'h1;
  localparam logic [1:0] OP_CLEAR      = 2'h2;
  localparam logic [7:0] DISP_WORD_SEL = 8'h00;

  // destination mode / register encodings
  localparam logic [2:0] MODE_DREG  = 3'h0;
  localparam logic [2:0] MODE_AREG  = 3'h1;
  localparam logic [2:0] MODE_EXT   = 3'h7;
  localparam logic [2:0] REG_ABS_L  = 3'h1;

  // program counter steps
  localparam logic [31:0] PC_STEP     = 32'h0000_0002;
  localparam logic [31:0] PC_STEP_EXT = 32'h0000_0004;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_DECODE,
    PH_FETCH_EXT,
    PH_EXEC,
    PH_MEM_RD,
    PH_MEM_WR
  } bccbe_phase_t;

  typedef struct packed {
    bccbe_phase_t     ph;
    logic             ack;
    logic [31:0]      rdat;
    logic [15:0]      opc;
    logic [15:0]      ext;
    logic [31:0]      pc;
    logic [CCR_W-1:0] ccr;
    logic [31:0]      ea;
    logic [7:0][31:0] d;
    logic             busy;
    logic             done;
    logic             invalid;
    logic             illegal;
    logic             mem_cyc;
    logic             mem_we;
    logic             mem_word;
    logic [31:0]      mem_adr;
    logic [7:0]       mem_dat;
  } bccbe_state_t;

endpackage

// [bccbe_props.sv]
/* bccbe_props: assertions on the ports of bccbe_top.
   assumes one clock, synchronous active-high reset, wishbone master
   that drops cyc/stb for a cycle after each ack. */
`timescale 1ns/1ps

module bccbe_props
  import bccbe_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        mem_cyc_o,
  input wire logic        mem_we_o,
  input wire logic        mem_word_o,
  input wire logic [31:0] mem_adr_o,
  input wire logic [7:0]  mem_dat_o,
  input wire logic [15:0] mem_dat_i,
  input wire logic        mem_ack_i,
  input wire logic        busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // register bus answers one cycle after the request
  chk_bus_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acked");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_busy_start: assert property (wb_ack_o && wb_we_i && wb_adr_i == ADR_OPCODE
    && wb_sel_i[0] && !busy_o |=> busy_o)
    else $error("opcode write did not start");
  // memory request held until answered
  chk_mem_hold: assert property (mem_cyc_o && !mem_ack_i
    |=> mem_cyc_o && $stable(mem_adr_o) && $stable(mem_we_o))
    else $error("memory request dropped early");
  // byte read is followed at once by write-back to the same byte
  chk_rd_to_wr: assert property (mem_cyc_o && mem_ack_i && !mem_we_o && !mem_word_o
    |=> mem_cyc_o && mem_we_o && $stable(mem_adr_o))
    else $error("no write-back after byte read");
  chk_wr_end: assert property (mem_cyc_o && mem_ack_i && mem_we_o
    |=> !mem_cyc_o && !busy_o)
    else $error("write-back did not finish");
  chk_wr_byte: assert property (mem_cyc_o && mem_we_o |-> !mem_word_o)
    else $error("memory write not a byte");
  chk_word_rd: assert property (mem_cyc_o && mem_word_o |-> !mem_we_o)
    else $error("word access is a write");
  chk_idle_mem: assert property (!busy_o |-> !mem_cyc_o)
    else $error("memory access while idle");
endmodule // bccbe_props

bind bccbe_top bccbe_props i_props (.*);

// [bccbe_tb.sv]
/* bccbe_tb: directed tests of bccbe_top with a memory model.
   assumes the register map and status bits of bccbe_pkg. */
`timescale 1ns/1ps

module bccbe_tb;
  import bccbe_pkg::*;
  localparam logic [7:0] D1 = 8'h24;
  localparam logic [7:0] D2 = 8'h28;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, mem_adr_o, q;
  logic [3:0]  wb_sel_i = 4'hF, dly = 4'h0;
  logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic        wb_ack_o, mem_cyc_o, mem_we_o, mem_word_o, mem_ack_i, busy_o;
  logic [7:0]  mem_dat_o;
  logic [15:0] mem_dat_i;
  logic [15:0] bad [3] = '{16'h0349, 16'h037C, 16'h6108};
  int          miscompares = 0, cmp_count = 0, cycles = 0;

  always #20 clk_i = ~clk_i;

  bccbe_top i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .mem_cyc_o(mem_cyc_o), .mem_we_o(mem_we_o), .mem_word_o(mem_word_o),
    .mem_adr_o(mem_adr_o), .mem_dat_o(mem_dat_o), .mem_dat_i(mem_dat_i),
    .mem_ack_i(mem_ack_i), .busy_o(busy_o));

  bccbe_mem_model i_mem (
    .clk_i(clk_i), .cyc_i(mem_cyc_o), .we_i(mem_we_o), .word_i(mem_word_o),
    .adr_i(mem_adr_o), .dat_i(mem_dat_o), .dly_i(dly), .dat_o(mem_dat_i),
    .ack_o(mem_ack_i));

  // hang guard; whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %0t: got %h want %h", $time, s, e);
    end
  endtask

  // classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  // start one instruction, wait for it, check pc and flags
  task automatic run(input logic [15:0] op, input logic [31:0] pc, input logic [4:0] cc);
    wb(1'b1, ADR_OPCODE, {16'h0000, op});
    do @(posedge clk_i); while (busy_o !== 1'b0);
    rd(ADR_PC, pc);
    rd(ADR_CCR, {27'h0, cc});
  endtask

  task automatic t_reg;
    wb(1'b1, ADR_CCR, 32'h1B);
    wb(1'b1, ADR_PC, 32'h40);
    wb(1'b1, D1, 32'd37);
    wb(1'b1, D2, 32'h20);
    run(16'h0342, 32'h42, 5'h1B);
    rd(D2, 32'h0);
    run(16'h0382, 32'h44, 5'h1F);
    rd(D2, 32'h0);
    run(16'h0842, 32'h48, 5'h1F);
    rd(D2, 32'h8000_0000);
    $display("test reg done");
  endtask

  task automatic t_mem;
    wb(1'b1, ADR_EA, 32'h90);
    dly <= 4'h3;
    run(16'h0890, 32'h4C, 5'h1B);
    chk(32'(i_mem.m[8'h90]), 32'h52);
    dly <= 4'h0;
    run(16'h0379, 32'h4E, 5'h1F);
    chk(32'(i_mem.m[8'h90]), 32'h72);
    $display("test mem done");
  endtask

  // bad destinations, then a non-branch of the branch layout
  task automatic t_bad;
    for (int i = 0; i < 3; i++) begin
      run(bad[i], 32'h4E, 5'h1F);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk(32'(q[i < 2 ? ST_INVALID : ST_ILLEGAL]), 32'h1);
    end
    $display("test bad done");
  endtask

  task automatic t_bra;
    run(16'h60F0, 32'h40, 5'h1F);
    run(16'h6000, 32'h32, 5'h1F);
    run(16'h6006, 32'h3A, 5'h1F);
    $display("test branch done");
  endtask

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // memory loaded while the bus is still quiet
  initial begin
    i_mem.m[8'h46] = 8'h00;
    i_mem.m[8'h47] = 8'hFF;
    i_mem.m[8'h4A] = 8'h00;
    i_mem.m[8'h4B] = 8'h0B;
    i_mem.m[8'h90] = 8'h5A;
    i_mem.m[8'h42] = 8'hFF;
    i_mem.m[8'h43] = 8'hF0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reg();
    t_mem();
    t_bad();
    t_bra();
    summarize();
  end
endmodule // bccbe_tb

// [bccbe_top.sv]
/*
 * bccbe_top: executes one instruction at a time: bit test-invert and bit
 * test-clear (static and dynamic bit number) and branch always (byte or
 * word displacement). Software loads pc, data registers and the resolved
 * operand address over classic wishbone, then writes the opcode word.
 * Assumes a memory port that holds ack for one cycle per request and
 * returns byte reads in the low eight bits of mem_dat_i.
 * Effective address arithmetic lives outside: software writes the byte
 * address of a memory operand, so postincrement and predecrement leave
 * no address register changed here.
 * Register writes that arrive while an instruction runs are acked and
 * dropped; software polls busy or status before the next opcode.
 */
// How it works
// - bit ops set z when tested bit was zero; other flags untouched
// - test-invert writes operand back with selected bit flipped
// - test-clear writes operand back with selected bit forced low
// - data register destination uses bit number modulo 32, whole long word
// - memory destination: read byte, bit number modulo 8, write byte back
// - long size only for data register, byte size for all memory modes
// - static bit number from second word, dynamic from named data register
// - dynamic invert: 0000 rrr 1 01 eeeeee
// - dynamic clear: 0000 rrr 1 10 eeeeee
// - static forms: 00001000 then 01 invert or 10 clear, number in next low byte
// - accepted destinations are the data alterable mode/register codes
// - branch target is instruction address plus two plus displacement
// - displacement is a signed byte distance
// - zero low byte selects a 16-bit signed displacement from next word
// - no short branch to the next instruction exists
// - branch leaves all condition flags unchanged
// - branch uses the conditional layout with the always-true condition
`timescale 1ns/1ps

module bccbe_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  output logic             mem_cyc_o,
  output logic             mem_we_o,
  output logic             mem_word_o,
  output logic      [31:0] mem_adr_o,
  output logic      [7:0]  mem_dat_o,
  input  wire logic [15:0] mem_dat_i,
  input  wire logic        mem_ack_i,
  output logic             busy_o
);
  import bccbe_pkg::*;

  bccbe_state_t s_r;
  bccbe_state_t s_nxt;

  // opcode fields
  // the bit op and branch formats share one set of slices; class decode picks the meaning
  logic [1:0]  op_sel;
  logic [2:0]  ea_mode;
  logic [2:0]  ea_reg;
  logic [2:0]  num_reg;
  logic [7:0]  disp8;
  assign op_sel  = s_r.opc[7:6];
  assign ea_mode = s_r.opc[5:3];
  assign ea_reg  = s_r.opc[2:0];
  assign num_reg = s_r.opc[11:9];
  assign disp8   = s_r.opc[7:0];

  // instruction classes
  logic is_bitop_code;
  logic is_branch;
  logic is_static;
  logic is_dynamic;
  logic ea_ok;
  logic need_ext;
  // only the always-true branch condition is decoded; other conditions land on illegal
  assign is_bitop_code = (op_sel == OP_INVERT) || (op_sel == OP_CLEAR);
  assign is_branch     = (s_r.opc[15:8] == OPC_BRANCH_HI);
  assign is_static     = (s_r.opc[15:8] == OPC_STATIC_HI) && is_bitop_code;
  assign is_dynamic    = (s_r.opc[15:12] == OPC_DYN_TOP) && s_r.opc[8]
                         && is_bitop_code;
  // address register, pc relative and immediate codes fall out here
  assign ea_ok         = (ea_mode != MODE_AREG)
                         && !((ea_mode == MODE_EXT) && (ea_reg > REG_ABS_L));
  // a zero short displacement always means a word follows, so no short hop of zero
  assign need_ext      = is_static || (is_branch && (disp8 == DISP_WORD_SEL));

  // bit number source and the shared test/modify datapath
  logic [31:0] bit_src;
  logic        in_mem;
  logic [31:0] operand;
  logic [4:0]  bit_num;
  logic [31:0] bit_mask;
  logic        bit_was_zero;
  logic [31:0] modified;
  // the memory operand only means something in the read phase while mem_ack_i is high
  assign bit_src      = is_static ? {24'h00_0000, s_r.ext[7:0]} : s_r.d[num_reg];
  assign in_mem       = (s_r.ph == PH_MEM_RD);
  assign operand      = in_mem ? {24'h00_0000, mem_dat_i[7:0]} : s_r.d[ea_reg];
  // byte operand sees modulo 8, register operand modulo 32
  assign bit_num      = in_mem ? {2'b00, bit_src[2:0]} : bit_src[4:0];
  assign bit_mask     = 32'h0000_0001 << bit_num;
  assign bit_was_zero = ~|(operand & bit_mask);
  assign modified     = (op_sel == OP_CLEAR) ? (operand & ~bit_mask)
                                             : (operand ^ bit_mask);

  // branch displacement, sign extended to the pc width
  // the word form takes the extension word, the byte form the opcode's low byte
  logic [31:0] disp;
  assign disp = (disp8 == DISP_WORD_SEL) ? 32'(signed'(s_r.ext))
                                         : 32'(signed'(disp8));

  // pc after a completed bit instruction
  // static forms carry one extension word, so they step four bytes, dynamic two
  logic [31:0] pc_after_bitop;
  assign pc_after_bitop = s_r.pc + (is_static ? PC_STEP_EXT : PC_STEP);

  // bus request decode
  logic bus_req;
  logic bus_wr;
  logic is_dreg_adr;
  assign bus_req     = wb_cyc_i & wb_stb_i;
  // the master must drop cyc and stb for a cycle between requests
  // a write lands only on the edge where the master sees ack
  assign bus_wr      = bus_req & wb_we_i & s_r.ack;
  assign is_dreg_adr = ((wb_adr_i & ADR_DREG_MASK) == ADR_DREG_BASE);

  // byte-lane merge for partial writes
  // unselected lanes keep their old bytes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // next-state: bus slave, then the execution sequencer
  // every field holds by default; each branch changes only what it owns
  always_comb begin
    logic [31:0] rd_v;
    rd_v  = 32'h0000_0000;
    s_nxt = s_r;

    // read mux; unmapped offsets answer zero
    // read data is captured when the request is taken and held until the next one
    if (is_dreg_adr) begin
      rd_v = s_r.d[wb_adr_i[4:2]];
    end else begin
      case (wb_adr_i)
        ADR_OPCODE: rd_v = {16'h0000, s_r.opc};
        ADR_PC:     rd_v = s_r.pc;
        ADR_CCR:    rd_v = {27'h000_0000, s_r.ccr};
        ADR_EA:     rd_v = s_r.ea;
        ADR_STATUS: begin
          rd_v[ST_BUSY]    = s_r.busy;
          rd_v[ST_DONE]    = s_r.done;
          rd_v[ST_INVALID] = s_r.invalid;
          rd_v[ST_ILLEGAL] = s_r.illegal;
        end
        default:    rd_v = 32'h0000_0000;
      endcase
    end
    s_nxt.ack = bus_req & ~s_r.ack;  // one-cycle ack, dropped after it was seen
    if (bus_req & ~s_r.ack) begin
      s_nxt.rdat = rd_v;
    end

    // writes only while idle, so software never races the sequencer
    if (bus_wr && (s_r.ph == PH_IDLE)) begin
      if (is_dreg_adr) begin
        s_nxt.d[wb_adr_i[4:2]] = lane_merge(s_r.d[wb_adr_i[4:2]], wb_dat_i, wb_sel_i);
      end else begin
        case (wb_adr_i)
          ADR_OPCODE: begin
            s_nxt.opc     = 16'(lane_merge({16'h0000, s_r.opc}, wb_dat_i, wb_sel_i));
            s_nxt.ph      = PH_DECODE;
            s_nxt.busy    = 1'b1;
            s_nxt.done    = 1'b0;
            s_nxt.invalid = 1'b0;
            s_nxt.illegal = 1'b0;
          end
          ADR_PC:  s_nxt.pc  = lane_merge(s_r.pc, wb_dat_i, wb_sel_i);
          ADR_CCR: s_nxt.ccr = CCR_W'(lane_merge({27'h000_0000, s_r.ccr}, wb_dat_i, wb_sel_i));
          ADR_EA:  s_nxt.ea  = lane_merge(s_r.ea, wb_dat_i, wb_sel_i);
          default: ;
        endcase
      end
    end

    // execution sequencer
    case (s_r.ph)
      PH_IDLE: ;
      PH_DECODE: begin
        // unknown opcode: flag it and leave every register alone
        if (!(is_branch || is_static || is_dynamic)) begin
          s_nxt.illegal = 1'b1;
          s_nxt.done    = 1'b1;
          s_nxt.busy    = 1'b0;
          s_nxt.ph      = PH_IDLE;
        end else if (need_ext) begin
          s_nxt.mem_cyc  = 1'b1;  // word after the opcode
          s_nxt.mem_we   = 1'b0;
          s_nxt.mem_word = 1'b1;
          s_nxt.mem_adr  = s_r.pc + PC_STEP;
          s_nxt.ph       = PH_FETCH_EXT;
        end else begin
          s_nxt.ph = PH_EXEC;
        end
      end
      PH_FETCH_EXT: begin
        // no timeout here: the memory side must answer every request
        if (mem_ack_i) begin
          s_nxt.ext     = mem_dat_i;
          s_nxt.mem_cyc = 1'b0;
          s_nxt.ph      = PH_EXEC;
        end
      end
      PH_EXEC: begin
        // pc base is the opcode address plus two for both displacement sizes
        if (is_branch) begin
          s_nxt.pc   = s_r.pc + PC_STEP + disp;
          s_nxt.done = 1'b1;
          s_nxt.busy = 1'b0;
          s_nxt.ph   = PH_IDLE;
        end else if (!ea_ok) begin
          // refused destination: nothing modified, flags untouched
          s_nxt.invalid = 1'b1;
          s_nxt.done    = 1'b1;
          s_nxt.busy    = 1'b0;
          s_nxt.ph      = PH_IDLE;
        end else if (ea_mode == MODE_DREG) begin
          // register destination finishes here with no memory traffic
          s_nxt.d[ea_reg]   = modified;
          s_nxt.ccr[CCR_Z]  = bit_was_zero;
          s_nxt.pc          = pc_after_bitop;
          s_nxt.done        = 1'b1;
          s_nxt.busy        = 1'b0;
          s_nxt.ph          = PH_IDLE;
        end else begin
          // memory destination: fetch the byte first, test and change it on its ack
          s_nxt.mem_cyc  = 1'b1;  // byte read of the operand
          s_nxt.mem_we   = 1'b0;
          s_nxt.mem_word = 1'b0;
          s_nxt.mem_adr  = s_r.ea;
          s_nxt.ph       = PH_MEM_RD;
        end
      end
      PH_MEM_RD: begin
        // z comes from the byte as read, before it is changed
        if (mem_ack_i) begin
          s_nxt.ccr[CCR_Z] = bit_was_zero;
          s_nxt.mem_we     = 1'b1;  // same address, byte written back
          s_nxt.mem_dat    = modified[7:0];
          s_nxt.ph         = PH_MEM_WR;
        end
      end
      PH_MEM_WR: begin
        // pc moves on only once the write-back has landed
        if (mem_ack_i) begin
          s_nxt.mem_cyc = 1'b0;
          s_nxt.mem_we  = 1'b0;
          s_nxt.pc      = pc_after_bitop;
          s_nxt.done    = 1'b1;
          s_nxt.busy    = 1'b0;
          s_nxt.ph      = PH_IDLE;
        end
      end
      // unused phase codes fall back to idle
      default: s_nxt.ph = PH_IDLE;
    endcase
  end

  // state register
  // synchronous reset clears pc, flags, data registers and the memory port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  // no output is combinational, so neither bus sees glitches
  assign wb_dat_o   = s_r.rdat;
  assign wb_ack_o   = s_r.ack;
  assign mem_cyc_o  = s_r.mem_cyc;
  assign mem_we_o   = s_r.mem_we;
  assign mem_word_o = s_r.mem_word;
  assign mem_adr_o  = s_r.mem_adr;
  assign mem_dat_o  = s_r.mem_dat;
  assign busy_o     = s_r.busy;

endmodule // bccbe_top
